// file: hdl/pqt_pkg.sv
// Shared constants, types and helpers for the packet queue block
package pqt_pkg;
	// Register offsets
	localparam logic [7:0] OFF_TX_CONTROL   = 8'h70;
	localparam logic [7:0] OFF_RX_HDR_STAT  = 8'h7C;
	localparam logic [7:0] OFF_RX_HDR_COUNT = 8'h7E;
	localparam logic [7:0] OFF_TX_FREE      = 8'h78;
	localparam logic [7:0] OFF_TXQ_CMD      = 8'h80;
	localparam logic [7:0] OFF_RXQ_CMD      = 8'h82;
	localparam logic [7:0] OFF_TX_PTR       = 8'h84;
	localparam logic [7:0] OFF_RX_PTR       = 8'h86;
	localparam logic [7:0] OFF_INT_EN       = 8'h90;
	localparam logic [7:0] OFF_INT_STATUS   = 8'h92;
	localparam logic [7:0] OFF_SPACE_REQ    = 8'h9E;
	localparam logic [7:0] OFF_QUEUE_DATA   = 8'hC0;
	// Field positions
	localparam int TXC_ENABLE   = 0;
	localparam int TXC_CRC      = 1;
	localparam int TXC_PAD      = 2;
	localparam int TXC_FLOW     = 3;
	localparam int QC_MANUAL    = 0;
	localparam int QC_SPACE     = 1;
	localparam int QC_AUTO      = 2;
	localparam int RQC_RELEASE  = 0;
	localparam int RQC_DMA      = 3;
	localparam int PTR_AUTOINC  = 14;
	localparam int INT_TX_DONE  = 14;
	localparam int INT_RX       = 13;
	localparam int INT_SPACE    = 6;
	localparam int CW_IRQ       = 15;
	// Writable bits: control bits 8:5 and 3:0, interrupt bits 14, 13, 6
	localparam logic [15:0] TXC_MASK = 16'h01EF;
	localparam logic [15:0] INT_MASK = 16'h6040;
	// Reset values
	localparam logic [15:0] RST_TX_CONTROL = 16'h0000;
	localparam logic [15:0] RST_INT_EN     = 16'h0000;
	localparam logic [15:0] RST_SPACE_REQ  = 16'h0000;
	// Memory sizes
	localparam logic [12:0] TX_MEM_BYTES = 13'h1800;
	localparam int          TX_WORDS     = 32'h0C00;
	localparam logic [10:0] RX_MAX_BYTES = 11'h7D0;
	localparam int          RX_WORDS     = 32'h03EA;
	localparam logic [12:0] HDR_BYTES    = 13'h0004;

	typedef enum logic [1:0] {TX_IDLE, TX_COUNT, TX_DATA, TX_DONE} pqt_tx_state_t;

	// Byte swap of a header word in big-endian mode
	function automatic logic [15:0] swap_hdr(input logic [15:0] v, input logic big);
		return big ? {v[7:0], v[15:8]} : v;
	endfunction
endpackage

// file: hdl/pqt_rx_store.sv
// Receive frame store: header words then packet data with CRC kept
`timescale 1ns/1ps
module pqt_rx_store (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Line side
	input  wire logic        line_valid,
	input  wire logic [7:0]  line_byte,
	input  wire logic        line_last,
	input  wire logic [15:0] line_status,
	output logic             line_ready,
	// Host side
	input  wire logic        big_endian,
	input  wire logic [9:0]  rd_addr,
	output logic [15:0]      rd_data,
	input  wire logic        release_frame,
	output logic             frame_stored,
	output logic [15:0]      hdr_status,
	output logic [15:0]      hdr_count
);
	typedef struct packed {
		logic        line_ready;
		logic        stored;
		logic [10:0] count;
		logic [15:0] status;
	} pqt_rx_t;

	pqt_rx_t     s;
	pqt_rx_t     n;
	logic [15:0] mem [pqt_pkg::RX_WORDS];
	logic [11:0] waddr;
	logic        wen;

	assign waddr = {1'b0, s.count} + 12'(pqt_pkg::HDR_BYTES);
	assign wen = s.line_ready && line_valid && s.count < pqt_pkg::RX_MAX_BYTES;

	always_comb begin
		n = s;
		n.stored = 1'b0;
		if (s.line_ready && line_valid) begin
			if (wen)
				n.count = s.count + 11'h001;
			if (line_last) begin
				n.status = line_status;
				n.line_ready = 1'b0;
				n.stored = 1'b1;
			end
		end
		if (release_frame && !s.line_ready) begin
			n.line_ready = 1'b1;
			n.count = 11'h000;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.line_ready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Data lands from byte offset 4; received bytes including CRC are kept up to the first 2000
	always_ff @(posedge clk) begin
		if (wen) begin
			if (waddr[0])
				mem[waddr[10:1]][15:8] <= line_byte;
			else
				mem[waddr[10:1]][7:0] <= line_byte;
		end
	end

	always_comb begin
		unique case (rd_addr)
			10'h000: rd_data = pqt_pkg::swap_hdr(s.status, big_endian);
			10'h001: rd_data = pqt_pkg::swap_hdr({5'h00, s.count}, big_endian);
			default: rd_data = mem[rd_addr];
		endcase
	end

	assign line_ready = s.line_ready;
	assign frame_stored = s.stored;
	assign hdr_status = s.status;
	assign hdr_count = {5'h00, s.count};

	a_rx_max_len: assert property (@(posedge clk) disable iff (reset)
		s.count <= pqt_pkg::RX_MAX_BYTES) else $error("receive count above limit");
endmodule

// file: hdl/pqt_tx_queue.sv
// Transmit queue control, register file and receive queue access
`timescale 1ns/1ps
module pqt_tx_queue (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Host register bus
	input  wire logic        bus_cs,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [1:0]  bus_be,
	input  wire logic [15:0] bus_wdata,
	output logic [15:0]      bus_rdata,
	output logic             irq_n,
	input  wire logic        big_endian,
	// Transmit line
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic [7:0]       tx_byte,
	output logic             tx_last,
	output logic [5:0]       tx_frame_id,
	output logic [8:0]       tx_options,
	output logic             tx_done,
	// Receive line
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_last,
	input  wire logic [15:0] rx_status,
	output logic             rx_ready
);
	typedef struct packed {
		logic [15:0]           tx_ctrl;
		logic [15:0]           int_en;
		logic [15:0]           int_stat;
		logic [15:0]           space_req;
		logic [15:0]           rdata;
		logic [12:0]           tx_ptr;
		logic                  tx_autoinc;
		logic [11:0]           rx_ptr;
		logic                  rx_autoinc;
		logic                  manual;
		logic                  space_arm;
		logic                  auto_q;
		logic                  dma_on;
		logic                  wrote;
		logic                  release_rx;
		logic [12:0]           used;
		logic [3:0]            pending;
		pqt_pkg::pqt_tx_state_t tx_st;
		logic [12:0]           rd_ptr;
		logic [10:0]           left;
		logic [12:0]           frame_bytes;
		logic [5:0]            fid;
		logic                  irq_fl;
		logic                  tx_valid;
		logic [7:0]            tx_byte;
		logic                  tx_last;
		logic                  tx_done;
		logic                  irq_n;
	} pqt_state_t;

	pqt_state_t  s;
	pqt_state_t  n;
	logic [15:0] tx_mem [pqt_pkg::TX_WORDS];
	logic [15:0] txw;
	logic [15:0] cw;
	logic [15:0] rx_word;
	logic [15:0] hdr_status;
	logic [15:0] hdr_count;
	logic [12:0] free;
	logic        rx_stored;
	logic        wr;
	logic        rd;
	logic        data_wr;
	logic        enq;
	logic        fire_tx;
	logic        fire_space;

	function automatic logic [12:0] wrap(input logic [12:0] p, input logic [12:0] inc);
		logic [13:0] t;
		t = {1'b0, p} + {1'b0, inc};
		if (t >= {1'b0, pqt_pkg::TX_MEM_BYTES})
			t = t - {1'b0, pqt_pkg::TX_MEM_BYTES};
		return t[12:0];
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] v,
		input logic [1:0] be);
		return {be[1] ? v[15:8] : o[15:8], be[0] ? v[7:0] : o[7:0]};
	endfunction

	pqt_rx_store u_rx (
		.clk          (clk),
		.reset        (reset),
		.line_valid   (rx_valid),
		.line_byte    (rx_byte),
		.line_last    (rx_last),
		.line_status  (rx_status),
		.line_ready   (rx_ready),
		.big_endian   (big_endian),
		.rd_addr      (s.rx_ptr[10:1]),
		.rd_data      (rx_word),
		.release_frame(s.release_rx),
		.frame_stored (rx_stored),
		.hdr_status   (hdr_status),
		.hdr_count    (hdr_count)
	);

	assign wr = bus_cs && bus_wr;
	assign rd = bus_cs && bus_rd;
	assign free = pqt_pkg::TX_MEM_BYTES - s.used;
	assign txw = tx_mem[s.rd_ptr[12:1]];
	assign cw = pqt_pkg::swap_hdr(txw, big_endian);
	// Frame data goes to memory only while the access window is open
	assign data_wr = wr && bus_addr == pqt_pkg::OFF_QUEUE_DATA && s.dma_on;

	always_comb begin
		n = s;
		n.tx_done = 1'b0;
		n.release_rx = 1'b0;
		enq = 1'b0;
		fire_tx = 1'b0;
		fire_space = 1'b0;

		// Transmit engine: control word, byte count, then data bytes
		unique case (s.tx_st)
			pqt_pkg::TX_IDLE: begin
				if (s.tx_ctrl[pqt_pkg::TXC_ENABLE] && s.pending != 4'h0) begin
					n.fid = cw[5:0];
					n.irq_fl = cw[pqt_pkg::CW_IRQ];
					n.rd_ptr = wrap(s.rd_ptr, 13'h0002);
					n.tx_st = pqt_pkg::TX_COUNT;
				end
			end
			pqt_pkg::TX_COUNT: begin
				n.left = cw[10:0];
				n.frame_bytes = pqt_pkg::HDR_BYTES + {2'b00, cw[10:0]} + {12'h000, cw[0]};
				n.rd_ptr = wrap(s.rd_ptr, 13'h0002);
				n.tx_st = pqt_pkg::TX_DATA;
			end
			pqt_pkg::TX_DATA: begin
				if (!s.tx_valid || tx_ready) begin
					n.tx_valid = 1'b1;
					n.tx_byte = s.rd_ptr[0] ? txw[15:8] : txw[7:0];
					n.tx_last = s.left == 11'h001;
					n.rd_ptr = wrap(s.rd_ptr, 13'h0001);
					n.left = s.left - 11'h001;
					if (s.left == 11'h001)
						n.tx_st = pqt_pkg::TX_DONE;
				end
			end
			pqt_pkg::TX_DONE: begin
				if (!s.tx_valid || tx_ready) begin
					n.tx_valid = 1'b0;
					n.tx_last = 1'b0;
					// Next frame starts word aligned
					n.rd_ptr = s.rd_ptr[0] ? wrap(s.rd_ptr, 13'h0001) : s.rd_ptr;
					n.tx_done = 1'b1;
					n.manual = 1'b0;
					fire_tx = s.irq_fl;
					n.tx_st = pqt_pkg::TX_IDLE;
				end
			end
		endcase

		// Space watch fires once and disarms itself
		if (s.space_arm && {5'h00, free} >= {s.space_req, 2'b00}) begin
			fire_space = 1'b1;
			n.space_arm = 1'b0;
		end

		if (wr) begin
			unique case (bus_addr)
				pqt_pkg::OFF_TX_CONTROL:
					n.tx_ctrl = merge(s.tx_ctrl, bus_wdata, bus_be) & pqt_pkg::TXC_MASK;
				pqt_pkg::OFF_TXQ_CMD: begin
					// A second manual request before the first is sent is ignored
					if (bus_wdata[pqt_pkg::QC_MANUAL] && !s.manual) begin
						n.manual = 1'b1;
						enq = 1'b1;
					end
					if (bus_wdata[pqt_pkg::QC_SPACE])
						n.space_arm = 1'b1;
					n.auto_q = bus_wdata[pqt_pkg::QC_AUTO];
				end
				pqt_pkg::OFF_RXQ_CMD: begin
					n.dma_on = bus_wdata[pqt_pkg::RQC_DMA];
					n.release_rx = bus_wdata[pqt_pkg::RQC_RELEASE];
					// Closing the window after writing data ends one prepared frame
					if (s.auto_q && s.dma_on && !bus_wdata[pqt_pkg::RQC_DMA] && s.wrote)
						enq = 1'b1;
				end
				pqt_pkg::OFF_TX_PTR: begin
					n.tx_ptr = bus_wdata[12:0];
					n.tx_autoinc = bus_wdata[pqt_pkg::PTR_AUTOINC];
				end
				pqt_pkg::OFF_RX_PTR: begin
					n.rx_ptr = bus_wdata[11:0];
					n.rx_autoinc = bus_wdata[pqt_pkg::PTR_AUTOINC];
				end
				pqt_pkg::OFF_INT_EN:
					n.int_en = merge(s.int_en, bus_wdata, bus_be) & pqt_pkg::INT_MASK;
				pqt_pkg::OFF_SPACE_REQ:
					n.space_req = merge(s.space_req, bus_wdata, bus_be);
				pqt_pkg::OFF_QUEUE_DATA: begin
					if (data_wr) begin
						n.wrote = 1'b1;
						if (s.tx_autoinc)
							n.tx_ptr = wrap(s.tx_ptr, 13'h0002);
					end
				end
				default: ;
			endcase
		end
		if (enq)
			n.wrote = 1'b0;

		// Write-one clear first, then new events, so a same-cycle event survives
		n.int_stat = s.int_stat;
		if (wr && bus_addr == pqt_pkg::OFF_INT_STATUS)
			n.int_stat = s.int_stat & ~(bus_wdata & pqt_pkg::INT_MASK);
		if (fire_tx)
			n.int_stat[pqt_pkg::INT_TX_DONE] = 1'b1;
		if (fire_space)
			n.int_stat[pqt_pkg::INT_SPACE] = 1'b1;
		if (rx_stored)
			n.int_stat[pqt_pkg::INT_RX] = 1'b1;

		n.pending = s.pending + {3'h0, enq} - {3'h0, n.tx_done};
		n.used = s.used + (data_wr ? 13'h0002 : 13'h0000)
			- (n.tx_done ? s.frame_bytes : 13'h0000);

		if (rd) begin
			unique case (bus_addr)
				pqt_pkg::OFF_TX_CONTROL:   n.rdata = s.tx_ctrl;
				pqt_pkg::OFF_TX_FREE:      n.rdata = {3'h0, free};
				pqt_pkg::OFF_TXQ_CMD:      n.rdata = {13'h0000, s.auto_q, s.space_arm, s.manual};
				pqt_pkg::OFF_RXQ_CMD:      n.rdata = {12'h000, s.dma_on, 3'h0};
				pqt_pkg::OFF_TX_PTR:       n.rdata = {1'b0, s.tx_autoinc, 1'b0, s.tx_ptr};
				pqt_pkg::OFF_RX_PTR:       n.rdata = {1'b0, s.rx_autoinc, 2'h0, s.rx_ptr};
				pqt_pkg::OFF_RX_HDR_STAT:  n.rdata = hdr_status;
				pqt_pkg::OFF_RX_HDR_COUNT: n.rdata = hdr_count;
				pqt_pkg::OFF_INT_EN:       n.rdata = s.int_en;
				pqt_pkg::OFF_INT_STATUS:   n.rdata = s.int_stat;
				pqt_pkg::OFF_SPACE_REQ:    n.rdata = s.space_req;
				pqt_pkg::OFF_QUEUE_DATA: begin
					n.rdata = s.dma_on ? rx_word : 16'h0000;
					if (s.dma_on && s.rx_autoinc)
						n.rx_ptr = s.rx_ptr + 12'h002;
				end
				default:                   n.rdata = 16'h0000;
			endcase
		end

		// One cycle behind the status so the pin is a plain flop
		n.irq_n = ~|(s.int_stat & s.int_en);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.tx_ctrl <= pqt_pkg::RST_TX_CONTROL;
			s.int_en <= pqt_pkg::RST_INT_EN;
			s.space_req <= pqt_pkg::RST_SPACE_REQ;
			s.irq_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	always_ff @(posedge clk) begin
		if (data_wr) begin
			if (bus_be[0])
				tx_mem[s.tx_ptr[12:1]][7:0] <= bus_wdata[7:0];
			if (bus_be[1])
				tx_mem[s.tx_ptr[12:1]][15:8] <= bus_wdata[15:8];
		end
	end

	assign bus_rdata = s.rdata;
	assign irq_n = s.irq_n;
	assign tx_valid = s.tx_valid;
	assign tx_byte = s.tx_byte;
	assign tx_last = s.tx_last;
	assign tx_frame_id = s.fid;
	assign tx_options = s.tx_ctrl[8:0];
	assign tx_done = s.tx_done;

	a_ctrl_write: assert property (@(posedge clk) disable iff (reset)
		wr && bus_addr == pqt_pkg::OFF_TX_CONTROL && bus_be == 2'b11
		|=> tx_options[3:0] == $past(bus_wdata[3:0])) else $error("control write lost");
	a_free_read: assert property (@(posedge clk) disable iff (reset)
		rd && bus_addr == pqt_pkg::OFF_TX_FREE
		|=> bus_rdata == {3'h0, pqt_pkg::TX_MEM_BYTES - $past(s.used)})
		else $error("free space read wrong");
	a_manual_set: assert property (@(posedge clk) disable iff (reset)
		wr && bus_addr == pqt_pkg::OFF_TXQ_CMD && bus_wdata[0] && !s.manual
		|=> s.manual && s.pending != 4'h0) else $error("manual enqueue not taken");
	a_manual_clear: assert property (@(posedge clk) disable iff (reset)
		tx_done |-> !s.manual) else $error("manual bit still set after send");
	a_space_fire: assert property (@(posedge clk) disable iff (reset)
		s.space_arm && {5'h00, free} >= {s.space_req, 2'b00}
		|=> s.int_stat[6] && !s.space_arm) else $error("space interrupt missed");
	a_done_irq: assert property (@(posedge clk) disable iff (reset)
		tx_done && $past(s.irq_fl) |-> s.int_stat[14]) else $error("done status missing");
	a_clear_all: assert property (@(posedge clk) disable iff (reset)
		wr && bus_addr == pqt_pkg::OFF_INT_STATUS && bus_wdata == 16'hFFFF
		&& !fire_tx && !fire_space && !rx_stored
		|=> s.int_stat == 16'h0000) else $error("status not cleared");
	a_irq_level: assert property (@(posedge clk) disable iff (reset)
		##1 irq_n == !(|($past(s.int_stat) & $past(s.int_en)))) else $error("irq level wrong");
	a_ptr_advance: assert property (@(posedge clk) disable iff (reset)
		data_wr && s.tx_autoinc && s.tx_ptr < 13'h17FE
		|=> s.tx_ptr == $past(s.tx_ptr) + 13'h0002) else $error("pointer not advanced");
endmodule

// file: test/pqt_line_model.sv
// Line side model: stalling transmit sink and receive frame source
`timescale 1ns/1ps
module pqt_line_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Transmit line
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_byte,
	input  wire logic        tx_last,
	input  wire logic [5:0]  tx_frame_id,
	input  wire logic        tx_done,
	output logic             tx_ready,
	// Receive line
	output logic             rx_valid,
	output logic [7:0]       rx_byte,
	output logic             rx_last,
	output logic [15:0]      rx_status,
	input  wire logic        rx_ready
);
	logic [7:0] got[$];
	logic [5:0] last_id;
	int         done_cnt;
	int         stall;
	int         stuck;

	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_last = 1'b0;
		rx_status = 16'h0000;
		last_id = 6'h00;
		done_cnt = 0;
		stall = 0;
		stuck = 0;
	end

	// Every third cycle refused, so held bytes are exercised
	always @(negedge clk) begin
		stall <= stall + 1;
		tx_ready <= (stall % 3) != 2;
	end

	always @(posedge clk) begin
		if (!reset && tx_valid && tx_ready) begin
			got.push_back(tx_byte);
			if (tx_last)
				last_id = tx_frame_id;
		end
		if (!reset && tx_done)
			done_cnt++;
	end

	// Bytes are A0 plus index; byte and status lines show inverse values once released
	task automatic send_frame(input int n, input logic [15:0] st);
		int i;
		int k;
		for (i = 0; i < n; i++) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_byte = 8'hA0 + i[7:0];
			rx_last = (i == n - 1);
			rx_status = st;
			k = 0;
			@(posedge clk);
			while (!rx_ready && k < 100) begin
				k++;
				@(posedge clk);
			end
			// A byte never taken is counted so the bench can fail the run
			if (k >= 100)
				stuck++;
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_byte = ~rx_byte;
		rx_status = ~rx_status;
	endtask
endmodule

// file: test/tb_top.sv
// Register level testbench for the transmit queue block
`timescale 1ns/1ps
module tb_top;
	logic clk, reset, bus_cs, bus_rd, bus_wr, irq_n, big_endian;
	logic [7:0] bus_addr, tx_byte, rx_byte;
	logic [1:0] bus_be;
	logic [15:0] bus_wdata, bus_rdata, rx_status;
	logic tx_valid, tx_ready, tx_last, tx_done, rx_valid, rx_last, rx_ready;
	logic [5:0] tx_frame_id;
	logic [8:0] tx_options;
	int num_errors = 0;
	int n_checks = 0;

	pqt_tx_queue pqt_tx_queue_inst (.clk(clk), .reset(reset), .bus_cs(bus_cs),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_be(bus_be),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .irq_n(irq_n),
		.big_endian(big_endian), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_byte(tx_byte), .tx_last(tx_last), .tx_frame_id(tx_frame_id),
		.tx_options(tx_options), .tx_done(tx_done), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_last(rx_last), .rx_status(rx_status), .rx_ready(rx_ready));

	pqt_line_model pqt_line_model_inst (.clk(clk), .reset(reset), .tx_valid(tx_valid),
		.tx_byte(tx_byte), .tx_last(tx_last), .tx_frame_id(tx_frame_id),
		.tx_done(tx_done), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_last(rx_last), .rx_status(rx_status), .rx_ready(rx_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held for one taking edge, then released a half cycle later
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		bus_cs = 1'b1;
		bus_wr = 1'b1;
		bus_addr = a;
		bus_wdata = d;
		@(negedge clk);
		bus_cs = 1'b0;
		bus_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		bus_cs = 1'b1;
		bus_rd = 1'b1;
		bus_addr = a;
		@(negedge clk);
		bus_cs = 1'b0;
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask

	// Control word, byte count, then two data words through the window
	task automatic put_frame(input logic [15:0] p, cw, bc, d0, d1);
		wr(8'h82, 16'h0008);
		wr(8'h84, p);
		wr(8'hC0, cw);
		wr(8'hC0, bc);
		wr(8'hC0, d0);
		wr(8'hC0, d1);
		wr(8'h82, 16'h0000);
	endtask

	task automatic wait_done(input int n);
		int k;
		k = 0;
		while (pqt_line_model_inst.done_cnt < n && k < 500) begin
			k++;
			@(negedge clk);
		end
		if (k >= 500) begin
			num_errors++;
			wrap_up();
		end
	endtask

	task automatic wait_rx_held();
		int k;
		k = 0;
		while (rx_ready !== 1'b0 && k < 50) begin
			k++;
			@(negedge clk);
		end
		if (k >= 50) begin
			num_errors++;
			wrap_up();
		end
	endtask

	initial begin
		{bus_cs, bus_rd, bus_wr, big_endian} = 4'h0;
		bus_addr = 8'h00;
		bus_be = 2'h3;
		bus_wdata = 16'h0000;
		reset = 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		rchk(pqt_pkg::OFF_TX_CONTROL, pqt_pkg::RST_TX_CONTROL);
		rchk(pqt_pkg::OFF_INT_EN, pqt_pkg::RST_INT_EN);
		rchk(pqt_pkg::OFF_SPACE_REQ, pqt_pkg::RST_SPACE_REQ);
		rchk(8'h78, {3'h0, pqt_pkg::TX_MEM_BYTES});
		rchk(8'h00, 16'h0000);
		rchk(8'hC0, 16'h0000);
		chk("irq_n", {15'h0000, irq_n}, 16'h0001);
		wr(8'h70, 16'hFFFF);
		rchk(8'h70, 16'h01EF);
		chk("tx_options", {7'h00, tx_options}, 16'h01EF);
		// Transmitter left off so the queued frame must wait
		wr(8'h70, 16'h01EE);
		wr(8'h90, 16'h4000);
		put_frame(16'h4000, 16'h8005, 16'h0003, 16'hBBAA, 16'h00CC);
		rchk(8'h78, 16'h17F8);
		wr(8'h80, 16'h0001);
		repeat (5) @(negedge clk);
		rchk(8'h80, 16'h0001);
		chk("tx_valid", {15'h0000, tx_valid}, 16'h0000);
		wr(8'h70, 16'h01EF);
		wait_done(1);
		repeat (2) @(negedge clk);
		chk("byte count", 16'(pqt_line_model_inst.got.size()), 16'h0003);
		chk("byte 0", {8'h00, pqt_line_model_inst.got[0]}, 16'h00AA);
		chk("byte 1", {8'h00, pqt_line_model_inst.got[1]}, 16'h00BB);
		chk("byte 2", {8'h00, pqt_line_model_inst.got[2]}, 16'h00CC);
		chk("frame id", {10'h000, pqt_line_model_inst.last_id}, 16'h0005);
		chk("irq_n", {15'h0000, irq_n}, 16'h0000);
		rchk(8'h80, 16'h0000);
		rchk(8'h78, 16'h1800);
		rchk(8'h92, 16'h4000);
		rchk(8'h92, 16'h4000);
		wr(8'h92, 16'h4000);
		rchk(8'h92, 16'h0000);
		repeat (2) @(negedge clk);
		chk("irq_n", {15'h0000, irq_n}, 16'h0001);
		// One double word short of free space, then exactly enough
		wr(8'h9E, 16'h0601);
		wr(8'h80, 16'h0002);
		repeat (5) @(negedge clk);
		rchk(8'h80, 16'h0002);
		rchk(8'h92, 16'h0000);
		wr(8'h9E, 16'h0600);
		repeat (3) @(negedge clk);
		rchk(8'h92, 16'h0040);
		rchk(8'h80, 16'h0000);
		chk("irq_n", {15'h0000, irq_n}, 16'h0001);
		wr(8'h90, 16'h4040);
		repeat (2) @(negedge clk);
		chk("irq_n", {15'h0000, irq_n}, 16'h0000);
		wr(8'h92, 16'hFFFF);
		repeat (2) @(negedge clk);
		rchk(8'h92, 16'h0000);
		chk("irq_n", {15'h0000, irq_n}, 16'h0001);
		// Low byte only: the high byte of the request must survive
		bus_be = 2'h1;
		wr(8'h9E, 16'hFFAB);
		bus_be = 2'h3;
		rchk(8'h9E, 16'h06AB);
		wr(8'h80, 16'h0004);
		put_frame(16'h4008, 16'h0009, 16'h0004, 16'h2211, 16'h4433);
		wait_done(2);
		repeat (2) @(negedge clk);
		chk("byte 3", {8'h00, pqt_line_model_inst.got[3]}, 16'h0011);
		chk("byte 6", {8'h00, pqt_line_model_inst.got[6]}, 16'h0044);
		chk("frame id", {10'h000, pqt_line_model_inst.last_id}, 16'h0009);
		rchk(8'h92, 16'h0000);
		rchk(8'h78, 16'h1800);
		// Oversized frame: count stops at the store limit
		pqt_line_model_inst.send_frame(2004, 16'h5A5A);
		wait_rx_held();
		wr(8'h86, 16'h4002);
		wr(8'h82, 16'h0008);
		rchk(8'hC0, {5'h00, pqt_pkg::RX_MAX_BYTES});
		wr(8'h82, 16'h0001);
		repeat (2) @(negedge clk);
		chk("rx_ready", {15'h0000, rx_ready}, 16'h0001);
		wr(8'h92, 16'hFFFF);
		pqt_line_model_inst.send_frame(5, 16'h1234);
		wait_rx_held();
		repeat (2) @(negedge clk);
		rchk(8'h92, 16'h2000);
		rchk(pqt_pkg::OFF_RX_HDR_STAT, 16'h1234);
		rchk(pqt_pkg::OFF_RX_HDR_COUNT, 16'h0005);
		wr(8'h86, 16'h4000);
		wr(8'h82, 16'h0008);
		rchk(8'hC0, 16'h1234);
		rchk(8'hC0, 16'h0005);
		rchk(8'hC0, 16'hA1A0);
		rchk(8'hC0, 16'hA3A2);
		big_endian = 1'b1;
		wr(8'h86, 16'h4000);
		rchk(8'hC0, 16'h3412);
		rchk(8'hC0, 16'h0500);
		big_endian = 1'b0;
		wr(8'h82, 16'h0001);
		chk("rx stalls", 16'(pqt_line_model_inst.stuck), 16'h0000);
		wrap_up();
	end
endmodule
